// [bench/dsp_host_model.sv]
module dsp_host_model
(
   input  wire logic run_i,
   output logic      mclk_o,
   output logic      bclk_o,
   output logic      fclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   initial mclk_o = 1'b0;
   always #41 mclk_o = ~mclk_o;
   // The link clocks stand low while the host is idle.
   always #97 n = run_i ? n + 1 : 0;
   assign bclk_o = run_i & n[0];
   assign fclk_o = run_i & n[5];
endmodule : dsp_host_model

// [bench/pll_clock_mode_and_lock_gating_tb_top.sv]
module pll_clock_mode_and_lock_gating_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk_i = 1'b0, nrst_i = 1'b0, tick = 1'b0, en = 1'b0;
   logic       ms = 1'b0, slow = 1'b0, mck_en = 1'b0, host_run = 1'b1;
   logic [3:0] ref_sel = 4'h4, rate = 4'hb;
   logic [1:0] div = 2'h0, brate = 2'h1;
   logic       dsp0 = 1'b1, dsp_msb_position = 1'b1, pol = 1'b0;
   logic       mck_in, h_bclk, h_fclk, mclk_o, bclk_o, fclk_o, g;
   logic       bclk_oe, fclk_oe, locked, sv, rp;
   clk_ctl_pkg::pll_cfg_s cfg;
   int         n_mismatch = 0, check_count = 0, seed = 36, c, t;
   logic [3:0] refs [13] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                             4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
   logic [3:0] rates [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                              4'h7, 4'ha, 4'hb, 4'he, 4'hf};
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) tick <= ~tick;
   dsp_host_model host
   (
      .run_i  (host_run),
      .mclk_o (mck_in),
      .bclk_o (h_bclk),
      .fclk_o (h_fclk)
   );
   pll_clock_mode_ctl
   #(
      .LOCK_FRAME_CYC     (21'h32),
      .LOCK_BIT_FAST_CYC  (21'h14),
      .LOCK_BIT_SLOW_CYC  (21'h1e),
      .LOCK_MCLK_CYC      (21'h28),
      .LOCK_MCLK_SLOW_CYC (21'h3c)
   )
   dut
   (
      .core_clk_i           (core_clk_i),
      .nrst_i               (nrst_i),
      .pll_tick_i           (tick),
      .pll_power_enable_i   (en),
      .master_select_i      (ms),
      .pll_ref_select_i     (ref_sel),
      .rate_select_i        (rate),
      .bclk_filter_slow_i   (slow),
      .mclk_out_enable_i    (mck_en),
      .mclk_out_divider_i   (div),
      .bit_clock_rate_i     (brate),
      .dsp_mode0_i          (dsp0),
      .dsp_msb_position_i   (dsp_msb_position),
      .bit_clock_polarity_i (pol),
      .mclk_in_i            (mck_in),
      .bit_clock_i          (bclk_oe ? bclk_o : h_bclk),
      .frame_clock_i        (fclk_oe ? fclk_o : h_fclk),
      .mclk_out_o           (mclk_o),
      .bit_clock_o          (bclk_o),
      .bit_clock_oe_o       (bclk_oe),
      .frame_clock_o        (fclk_o),
      .frame_clock_oe_o     (fclk_oe),
      .pll_locked_o         (locked),
      .samples_valid_o      (sv),
      .ref_present_o        (rp),
      .clk_cfg_o            (cfg)
   );
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #5;
   endtask : cyc
   task automatic wait_lock();
      for (c = 0; locked !== 1'b1; c++)
      begin
         cyc(1);
         if (c > 300)
         begin
            chk("lock_wait", 1, 0);
            final_report();
         end
      end
   endtask : wait_lock
   // Measures the cycles between two rising edges of one output.
   task automatic period(input int s);
      int r1;
      logic pv;
      logic cur;
      r1 = -1;
      pv = 1'b1;
      c = 0;
      for (int k = 0; c == 0; k++)
      begin
         cyc(1);
         cur = s == 0 ? fclk_o : s == 1 ? bclk_o : mclk_o;
         if (cur === 1'b1 && pv === 1'b0 && r1 >= 0)
            c = k - r1;
         else if (cur === 1'b1 && pv === 1'b0)
            r1 = k;
         pv = cur;
         if (k > 3000)
         begin
            chk("period_wait", 1, 0);
            final_report();
         end
      end
   endtask : period
   function automatic int lock_exp(input logic [3:0] r, input logic s);
      if (r == 4'h0)
         return 50;
      if (r[3:1] == 3'h1)
         return s ? 30 : 20;
      return r[3:1] == 3'h7 ? 60 : 40;
   endfunction : lock_exp
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   initial
   begin
      cyc(3);
      chk("locked_in_reset", 0, locked);
      nrst_i = 1'b1;
      foreach (refs[i])
      begin
         ref_sel = refs[i];
         slow = 1'($random(seed));
         rate = rates[$unsigned($random(seed)) % 12];
         div = 2'($random(seed));
         mck_en = 1'b1;
         t = lock_exp(ref_sel, slow);
         cyc(80);
         en = 1'b1;
         wait_lock();
         chk("lock_time", 1, c >= t && c <= t + 4);
         chk("src", ref_sel == 4'h0 ? clk_ctl_pkg::SRC_FRAME :
             ref_sel[3:1] == 3'h1 ? clk_ctl_pkg::SRC_BIT :
             clk_ctl_pkg::SRC_MCLK, cfg.src);
         chk("oe_slave", 0, bclk_oe | fclk_oe);
         chk("samples_valid", 1, sv);
         period(2);
         chk("slave_mclk", 4 << div, c);
         en = 1'b0;
      end
      $display("test lock_time done");
      ms = 1'b1;
      host_run = 1'b0;
      ref_sel = 4'h4;
      for (int k = 0; k < 4; k++)
      begin
         div = 2'(k);
         brate = k[0] ? 2'h2 : 2'h1;
         rate = rates[$unsigned($random(seed)) % 12];
         // The first pass always asks for the shortened first pulse.
         dsp0 = k == 0 ? 1'b1 : 1'($random(seed));
         dsp_msb_position = 1'($random(seed));
         pol = k == 0 ? ~dsp_msb_position : 1'($random(seed));
         mck_en = 1'b1;
         cyc(3);
         chk("oe_master", 1, bclk_oe & fclk_oe);
         en = 1'b1;
         g = 1'b0;
         repeat (30)
         begin
            cyc(1);
            g = g | bclk_o | fclk_o;
         end
         chk("gated_during_lock", 0, g);
         wait_lock();
         cyc(3);
         chk("left_first", 1, fclk_o);
         // Count the high cycles of the first bit clock pulse.
         g = 1'b0;
         t = 0;
         for (c = 0; c < 60 && !(g && !bclk_o); c++)
         begin
            cyc(1);
            t = t + int'(bclk_o);
            g = g | bclk_o;
         end
         chk("first_bclk_high",
             (brate == 2'h1 ? 16 : 8) - ((dsp0 && dsp_msb_position != pol) ? 4 : 0), t);
         period(0);
         chk("frame_period", 1024, c);
         period(1);
         chk("bclk_period", brate == 2'h1 ? 32 : 16, c);
         period(2);
         chk("mclk_period", 4 << k, c);
         mck_en = 1'b0;
         cyc(4);
         g = 1'b0;
         repeat (40)
         begin
            cyc(1);
            g = g | mclk_o;
         end
         chk("mclk_off", 0, g);
         brate = k[1] ? 2'h3 : 2'h0;
         cyc(2);
         g = 1'b0;
         repeat (40)
         begin
            cyc(1);
            g = g | bclk_o;
         end
         chk("bclk_unsupported", 0, g);
         rate = rate ^ 4'h1;
         cyc(3);
         chk("relock", 0, locked | sv);
         en = 1'b0;
         cyc(3);
         chk("off_low", 0, bclk_o | fclk_o);
      end
      $display("test master done");
      ms = 1'b0;
      ref_sel = 4'h0;
      cyc(4200);
      chk("ref_absent", 0, rp);
      en = 1'b1;
      cyc(100);
      chk("held_unlocked", 0, locked);
      host_run = 1'b1;
      wait_lock();
      chk("late_lock", 1, locked);
      $display("test ref_absent done");
      final_report();
   end
endmodule : pll_clock_mode_and_lock_gating_tb_top

// [common/clk_ctl_pkg.sv]
package clk_ctl_pkg;

   // Core clock rate in kHz; lock times below are in milliseconds.
   localparam int CLK_KHZ           = 20000;
   localparam int LOCK_FRAME_MS     = 80;
   localparam int LOCK_BIT_FAST_MS  = 2;
   localparam int LOCK_BIT_SLOW_MS  = 4;
   localparam int LOCK_MCLK_MS      = 40;
   localparam int LOCK_MCLK_SLOW_MS = 60;
   localparam int LOCK_W            = 21;

   localparam logic [20:0] LOCK_FRAME_CYCLES =
      21'(LOCK_FRAME_MS * CLK_KHZ);
   localparam logic [20:0] LOCK_BIT_FAST_CYCLES =
      21'(LOCK_BIT_FAST_MS * CLK_KHZ);
   localparam logic [20:0] LOCK_BIT_SLOW_CYCLES =
      21'(LOCK_BIT_SLOW_MS * CLK_KHZ);
   localparam logic [20:0] LOCK_MCLK_CYCLES =
      21'(LOCK_MCLK_MS * CLK_KHZ);
   localparam logic [20:0] LOCK_MCLK_SLOW_CYCLES =
      21'(LOCK_MCLK_SLOW_MS * CLK_KHZ);

   // A reference with no edge for this many cycles counts as absent.
   localparam logic [12:0] REF_TIMEOUT_CYCLES = 13'h1000;

   // Phase counter runs on a 512fs tick, so one wrap is one frame.
   localparam int         PHASE_W      = 9;
   localparam logic [8:0] PHASE_RESET  = 9'h000;
   localparam logic [8:0] HALF_32FS    = 9'h008;
   localparam logic [8:0] HALF_64FS    = 9'h004;
   localparam logic [8:0] SHORT_TICKS  = 9'h002;
   localparam int         FRAME_BIT    = 8;
   localparam int         BCLK32_BIT   = 3;
   localparam int         BCLK64_BIT   = 2;

   localparam logic [3:0] REF_FRAME_1FS  = 4'h0;
   localparam logic [3:0] REF_BIT_32FS   = 4'h2;
   localparam logic [3:0] REF_BIT_64FS   = 4'h3;
   localparam logic [3:0] REF_MCLK_11M29 = 4'h4;
   localparam logic [3:0] REF_MCLK_12M29 = 4'h5;
   localparam logic [3:0] REF_MCLK_12M   = 4'h6;
   localparam logic [3:0] REF_MCLK_24M   = 4'h7;
   localparam logic [3:0] REF_MCLK_19M2  = 4'h8;
   localparam logic [3:0] REF_MCLK_12M_LJ = 4'h9;
   localparam logic [3:0] REF_MCLK_13M5  = 4'hc;
   localparam logic [3:0] REF_MCLK_27M   = 4'hd;
   localparam logic [3:0] REF_MCLK_13M   = 4'he;
   localparam logic [3:0] REF_MCLK_26M   = 4'hf;

   localparam logic [1:0] BCLK_RATE_32FS = 2'h1;
   localparam logic [1:0] BCLK_RATE_64FS = 2'h2;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_FRAME,
      SRC_BIT,
      SRC_MCLK
   } ref_src_e;

   typedef struct packed {
      ref_src_e   src;
      logic [3:0] ref_code;
      logic [3:0] rate_code;
      logic [1:0] rate_range;
      logic       rate_offset;
      logic       valid;
   } pll_cfg_s;

   function automatic ref_src_e ref_source(input logic [3:0] code);
      ref_src_e s;
      s = SRC_NONE;
      if (code == REF_FRAME_1FS)
         s = SRC_FRAME;
      else if (code == REF_BIT_32FS || code == REF_BIT_64FS)
         s = SRC_BIT;
      else if (code >= REF_MCLK_11M29 && code <= REF_MCLK_12M_LJ)
         s = SRC_MCLK;
      else if (code >= REF_MCLK_13M5)
         s = SRC_MCLK;
      return s;
   endfunction : ref_source

   function automatic logic rate_code_ok(input logic [3:0] r);
      return (r[3] == 1'b0) || (r[1] == 1'b1);
   endfunction : rate_code_ok

endpackage : clk_ctl_pkg

// [hdl/audio_clock_gen.sv]
module audio_clock_gen
(
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       tick_i,
   input  wire logic       run_i,
   input  wire logic [1:0] mclk_div_i,
   input  wire logic [1:0] bclk_rate_i,
   input  wire logic       short_first_i,
   output logic            mclk_o,
   output logic            bclk_o,
   output logic            frame_o
);

   logic [8:0] phase_reg;
   logic [8:0] phase_next;
   logic       running_reg;
   logic       running_next;
   logic       first_reg;
   logic       first_next;
   logic       bclk_raw;
   logic [8:0] half;
   logic       mask;

   always_comb
   begin
      half = (bclk_rate_i == clk_ctl_pkg::BCLK_RATE_64FS) ?
             clk_ctl_pkg::HALF_64FS : clk_ctl_pkg::HALF_32FS;
      unique case (bclk_rate_i)
         clk_ctl_pkg::BCLK_RATE_32FS:
            bclk_raw = phase_reg[clk_ctl_pkg::BCLK32_BIT];   // RULE21
         clk_ctl_pkg::BCLK_RATE_64FS:
            bclk_raw = phase_reg[clk_ctl_pkg::BCLK64_BIT];   // RULE21
         default:
            bclk_raw = 1'b0;
      endcase
      phase_next   = phase_reg;
      running_next = run_i;
      first_next   = first_reg;
      // Restart at phase zero so the first frame carries left data.
      if (run_i && !running_reg)
      begin
         phase_next = clk_ctl_pkg::PHASE_RESET;                // RULE14
         first_next = 1'b1;
      end
      else if (tick_i)
      begin
         phase_next = 9'(phase_reg + 9'h001);
      end
      if (running_reg && phase_reg >= 9'(half << 1))
      begin
         first_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         phase_reg   <= clk_ctl_pkg::PHASE_RESET;
         running_reg <= 1'b0;
         first_reg   <= 1'b0;
      end
      else
      begin
         phase_reg   <= phase_next;
         running_reg <= running_next;
         first_reg   <= first_next;
      end
   end

   // The first high pulse loses two ticks when asked to.
   assign mask    = first_reg && short_first_i &&
                    (phase_reg < 9'(half + clk_ctl_pkg::SHORT_TICKS)); // RULE15
   assign bclk_o  = running_reg && bclk_raw && !mask;
   assign frame_o = running_reg && !phase_reg[clk_ctl_pkg::FRAME_BIT]; // RULE13
   assign mclk_o  = phase_reg[mclk_div_i];                           // RULE20

endmodule : audio_clock_gen

// [hdl/pll_clock_mode_ctl.sv]
// Functional notes
// RULE1 - PLL enable derives clocks from selected reference
// RULE2 - Unlocked for lock time after enable/rate change
// RULE3 - Code 0000: frame clock reference, 80ms lock
// RULE4 - Codes 0010/0011: bit clock reference, 2/4ms
// RULE5 - Codes 0100-0111: master clock input, 40ms
// RULE6 - 1000 is 19.2MHz; 1001 low-jitter 12MHz
// RULE7 - 1100/1101 40ms; 1110/1111 60ms lock
// RULE8 - Master-clock reference: 8k to 48k rate codes
// RULE9 - 44.1k family codes; offset under 1001
// RULE10 - Pin reference: rate range from upper bits
// RULE11 - Master first lock: bit/frame low, mclk irregular
// RULE12 - Master relock: clock outputs are invalid
// RULE13 - Master locked: 1fs frame, selected bit clock
// RULE14 - DSP mode 0 starts on left channel
// RULE15 - First bit clock pulse may be shortened
// RULE16 - Software disables PLL before rate change
// RULE17 - Slave: mclk invalid then divided clock
// RULE18 - Samples invalid while unlocked
// RULE19 - Master role drives bit and frame clocks
// RULE20 - Divider gives 256/128/64/32fs master clock
// RULE21 - Bit clock rate 01 32fs, 10 64fs
// RULE22 - Unsupported select codes are not used
// RULE23 - Lock modelled by a counter per reference
module pll_clock_mode_ctl
#(
   parameter logic [20:0] LOCK_FRAME_CYC     =
      clk_ctl_pkg::LOCK_FRAME_CYCLES,
   parameter logic [20:0] LOCK_BIT_FAST_CYC  =
      clk_ctl_pkg::LOCK_BIT_FAST_CYCLES,
   parameter logic [20:0] LOCK_BIT_SLOW_CYC  =
      clk_ctl_pkg::LOCK_BIT_SLOW_CYCLES,
   parameter logic [20:0] LOCK_MCLK_CYC      =
      clk_ctl_pkg::LOCK_MCLK_CYCLES,
   parameter logic [20:0] LOCK_MCLK_SLOW_CYC =
      clk_ctl_pkg::LOCK_MCLK_SLOW_CYCLES
)
(
   input  wire logic           core_clk_i,
   input  wire logic           nrst_i,
   input  wire logic           pll_tick_i,
   input  wire logic           pll_power_enable_i,
   input  wire logic           master_select_i,
   input  wire logic [3:0]     pll_ref_select_i,
   input  wire logic [3:0]     rate_select_i,
   input  wire logic           bclk_filter_slow_i,
   input  wire logic           mclk_out_enable_i,
   input  wire logic [1:0]     mclk_out_divider_i,
   input  wire logic [1:0]     bit_clock_rate_i,
   input  wire logic           dsp_mode0_i,
   input  wire logic           dsp_msb_position_i,
   input  wire logic           bit_clock_polarity_i,
   input  wire logic           mclk_in_i,
   input  wire logic           bit_clock_i,
   input  wire logic           frame_clock_i,
   output logic                mclk_out_o,
   output logic                bit_clock_o,
   output logic                bit_clock_oe_o,
   output logic                frame_clock_o,
   output logic                frame_clock_oe_o,
   output logic                pll_locked_o,
   output logic                samples_valid_o,
   output logic                ref_present_o,
   output clk_ctl_pkg::pll_cfg_s clk_cfg_o
);

   typedef enum logic [1:0] {
      ST_OFF,
      ST_FIRST_LOCK,
      ST_LOCKED,
      ST_RELOCK
   } lock_state_e;

   lock_state_e           state_reg;
   lock_state_e           state_next;
   logic [20:0]           lock_cnt_reg;
   logic [20:0]           lock_cnt_next;
   logic [3:0]            rate_seen_reg;
   logic [3:0]            ref_seen_reg;
   logic [2:0]            pin_meta_reg;
   logic [2:0]            pin_sync_reg;
   logic [2:0]            pin_last_reg;
   logic [12:0]           ref_idle_reg;
   logic [12:0]           ref_idle_next;
   logic                  mclk_out_reg;
   logic                  mclk_out_next;
   logic                  bclk_reg;
   logic                  bclk_next;
   logic                  frame_reg;
   logic                  frame_next;
   logic                  oe_reg;
   clk_ctl_pkg::pll_cfg_s cfg_reg;
   clk_ctl_pkg::pll_cfg_s cfg_next;
   clk_ctl_pkg::ref_src_e src;
   logic                  ref_edge;
   logic                  ref_ok;
   logic                  cfg_change;
   logic [20:0]           lock_target;
   logic                  gen_run;
   logic                  gen_mclk;
   logic                  gen_bclk;
   logic                  gen_frame;

   // Lock time for each reference choice, in core clock cycles.
   function automatic logic [20:0] lock_cycles(input logic [3:0] code,
                                               input logic slow);
      logic [20:0] c;
      c = LOCK_MCLK_CYC;                                      // RULE5
      if (code == clk_ctl_pkg::REF_FRAME_1FS)
         c = LOCK_FRAME_CYC;                                  // RULE3
      else if (code == clk_ctl_pkg::REF_BIT_32FS ||
               code == clk_ctl_pkg::REF_BIT_64FS)
         c = slow ? LOCK_BIT_SLOW_CYC : LOCK_BIT_FAST_CYC;    // RULE4
      else if (code == clk_ctl_pkg::REF_MCLK_13M ||
               code == clk_ctl_pkg::REF_MCLK_26M)
         c = LOCK_MCLK_SLOW_CYC;                              // RULE7
      return c;
   endfunction : lock_cycles

   // Reference pins come from outside: two flops, then edge detect.
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         pin_last_reg <= 3'h0;
      end
      else
      begin
         pin_meta_reg <= {mclk_in_i, bit_clock_i, frame_clock_i};
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   always_comb
   begin
      src = clk_ctl_pkg::ref_source(pll_ref_select_i);        // RULE1
      unique case (src)
         clk_ctl_pkg::SRC_FRAME:
            ref_edge = pin_sync_reg[0] && !pin_last_reg[0];   // RULE3
         clk_ctl_pkg::SRC_BIT:
            ref_edge = pin_sync_reg[1] && !pin_last_reg[1];   // RULE4
         clk_ctl_pkg::SRC_MCLK:
            ref_edge = pin_sync_reg[2] && !pin_last_reg[2];   // RULE5
         clk_ctl_pkg::SRC_NONE:
            ref_edge = 1'b0;
      endcase
      ref_idle_next = ref_idle_reg;
      if (ref_edge)
         ref_idle_next = 13'h0000;
      else if (ref_idle_reg < clk_ctl_pkg::REF_TIMEOUT_CYCLES)
         ref_idle_next = 13'(ref_idle_reg + 13'h0001);
   end

   assign ref_ok = ref_idle_reg < clk_ctl_pkg::REF_TIMEOUT_CYCLES;

   // Configuration decode seen by the analog loop and the ADC.
   always_comb
   begin
      cfg_next.src         = src;
      cfg_next.ref_code    = pll_ref_select_i;                // RULE6
      cfg_next.rate_code   = rate_select_i;                   // RULE8
      cfg_next.rate_range  = rate_select_i[3] ? 2'h2 :
                             {1'b0, rate_select_i[2]};        // RULE10
      cfg_next.rate_offset = (src == clk_ctl_pkg::SRC_MCLK) &&
         (pll_ref_select_i == clk_ctl_pkg::REF_MCLK_12M_LJ) &&
         rate_select_i[2];                                    // RULE9
      cfg_next.valid = (src != clk_ctl_pkg::SRC_NONE) &&
         ((src != clk_ctl_pkg::SRC_MCLK) ||
          clk_ctl_pkg::rate_code_ok(rate_select_i));          // RULE8
   end

   assign cfg_change  = (rate_select_i != rate_seen_reg) ||
                        (pll_ref_select_i != ref_seen_reg);
   assign lock_target = lock_cycles(pll_ref_select_i, bclk_filter_slow_i);

   always_comb
   begin
      state_next    = state_reg;
      lock_cnt_next = lock_cnt_reg;
      if (!pll_power_enable_i)
      begin
         state_next    = ST_OFF;
         lock_cnt_next = 21'h000000;
      end
      else
      begin
         unique case (state_reg)
            ST_OFF:
            begin
               state_next    = ST_FIRST_LOCK;                 // RULE2
               lock_cnt_next = 21'h000000;
            end
            ST_FIRST_LOCK, ST_RELOCK:
            begin
               if (cfg_change)
                  lock_cnt_next = 21'h000000;                 // RULE2
               else if (ref_ok)
               begin
                  if (lock_cnt_reg >= 21'(lock_target - 21'h000001))
                     state_next = ST_LOCKED;                  // RULE23
                  else
                     lock_cnt_next = 21'(lock_cnt_reg + 21'h000001);
               end
            end
            ST_LOCKED:
            begin
               if (cfg_change)
               begin
                  state_next    = ST_RELOCK;                  // RULE2
                  lock_cnt_next = 21'h000000;
               end
            end
         endcase
      end
   end

   assign gen_run = (state_reg == ST_LOCKED) ||
                    (state_reg == ST_RELOCK);

   audio_clock_gen u_gen
   (
      .core_clk_i    (core_clk_i),
      .nrst_i        (nrst_i),
      .tick_i        (pll_tick_i),
      .run_i         (gen_run),
      .mclk_div_i    (mclk_out_divider_i),
      .bclk_rate_i   (bit_clock_rate_i),
      .short_first_i (dsp_mode0_i &&
                      (dsp_msb_position_i != bit_clock_polarity_i)),
      .mclk_o        (gen_mclk),
      .bclk_o        (gen_bclk),
      .frame_o       (gen_frame)
   );

   // Before first lock the frame and bit clocks are held low; during
   // a relock they keep running but carry no valid timing.
   always_comb
   begin
      mclk_out_next = mclk_out_enable_i && (state_reg != ST_OFF) &&
                      gen_mclk;                               // RULE17
      bclk_next  = 1'b0;                                      // RULE16
      frame_next = 1'b0;
      if (master_select_i && gen_run)
      begin
         bclk_next  = gen_bclk;                               // RULE12
         frame_next = gen_frame;                              // RULE13
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg     <= ST_OFF;
         lock_cnt_reg  <= 21'h000000;
         rate_seen_reg <= 4'h0;
         ref_seen_reg  <= 4'h0;
         ref_idle_reg  <= clk_ctl_pkg::REF_TIMEOUT_CYCLES;
         mclk_out_reg  <= 1'b0;
         bclk_reg      <= 1'b0;
         frame_reg     <= 1'b0;
         oe_reg        <= 1'b0;
         cfg_reg       <= '0;
      end
      else
      begin
         state_reg     <= state_next;
         lock_cnt_reg  <= lock_cnt_next;
         rate_seen_reg <= rate_select_i;
         ref_seen_reg  <= pll_ref_select_i;
         ref_idle_reg  <= ref_idle_next;
         mclk_out_reg  <= mclk_out_next;                      // RULE11
         bclk_reg      <= bclk_next;                          // RULE11
         frame_reg     <= frame_next;
         oe_reg        <= master_select_i;                    // RULE19
         cfg_reg       <= cfg_next;
      end
   end

   assign mclk_out_o       = mclk_out_reg;
   assign bit_clock_o      = bclk_reg;
   assign frame_clock_o    = frame_reg;
   assign bit_clock_oe_o   = oe_reg;
   assign frame_clock_oe_o = oe_reg;
   assign pll_locked_o     = (state_reg == ST_LOCKED);
   assign samples_valid_o  = (state_reg == ST_LOCKED);         // RULE18
   assign ref_present_o    = ref_ok;
   assign clk_cfg_o        = cfg_reg;

   property p_off_low;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !pll_power_enable_i ##1 !pll_power_enable_i |=>
         !bit_clock_o && !frame_clock_o && !mclk_out_o;
   endproperty
   a_off_low: assert property (p_off_low) // RULE16
      else $error("clock output active with PLL disabled");

   property p_first_lock_low;
      @(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ST_FIRST_LOCK |=> !bit_clock_o && !frame_clock_o;
   endproperty
   a_first_lock_low: assert property (p_first_lock_low) // RULE11
      else $error("bit or frame clock toggles before first lock");

   property p_mclk_gated;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !mclk_out_enable_i |=> !mclk_out_o;
   endproperty
   a_mclk_gated: assert property (p_mclk_gated) // RULE17
      else $error("master clock output high while disabled");

   property p_slave_no_drive;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !master_select_i |=> !bit_clock_oe_o && !frame_clock_oe_o &&
                           !bit_clock_o && !frame_clock_o;
   endproperty
   a_slave_no_drive: assert property (p_slave_no_drive) // RULE19
      else $error("slave role drives bit or frame clock");

   property p_no_early_lock;
      @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(pll_power_enable_i) |=> !pll_locked_o [*8];
   endproperty
   a_no_early_lock: assert property (p_no_early_lock) // RULE2
      else $error("lock reported too soon after enable");

   property p_rate_change_unlocks;
      @(posedge core_clk_i) disable iff (!nrst_i)
      pll_locked_o && pll_power_enable_i &&
      rate_select_i != rate_seen_reg |=> !pll_locked_o ##1 !pll_locked_o;
   endproperty
   a_rate_change_unlocks: assert property (p_rate_change_unlocks) // RULE2
      else $error("rate change did not drop lock");

   property p_samples_follow_lock;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !pll_power_enable_i |=> !samples_valid_o;
   endproperty
   a_samples_follow_lock: assert property (p_samples_follow_lock) // RULE18
      else $error("samples marked valid while unlocked");

   property p_left_first;
      @(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ST_FIRST_LOCK ##1 state_reg == ST_LOCKED &&
      master_select_i |-> ##2 (frame_clock_o || !master_select_i);
   endproperty
   a_left_first: assert property (p_left_first) // RULE14
      else $error("first frame after lock is not left channel");

   property p_range_decode;
      @(posedge core_clk_i) disable iff (!nrst_i)
      1'b1 |=> clk_cfg_o.rate_range ==
         ($past(rate_select_i[3]) ? 2'h2 : {1'b0, $past(rate_select_i[2])});
   endproperty
   a_range_decode: assert property (p_range_decode) // RULE10
      else $error("rate range decode wrong");

   property p_lock_needs_count;
      @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(pll_locked_o) |-> $past(lock_cnt_reg) >= 21'(lock_target - 1);
   endproperty
   a_lock_needs_count: assert property (p_lock_needs_count) // RULE23
      else $error("lock reached before lock time elapsed");

endmodule : pll_clock_mode_ctl
